/* File: src/ahs_serial.sv */
// Device-side serial port, ready pin and general output update
`timescale 1ns/1ps
`include "ahs_consts.svh"
module ahs_serial
    import ahs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mod_clk_en,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic start_pin,
    input wire logic [15:0] result_word,
    output logic serial_out,
    output logic serial_out_oe,
    output logic result_ready_n,
    output logic [3:0] general_io_pin
);
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] ck_s;
        logic [1:0] di_s;
        logic [1:0] st_s;
        logic ck_d;
        logic st_d;
        logic [2:0] bitcnt;
        logic [7:0] shin;
        logic [15:0] shout;
        logic [15:0] tmo;
        ahs_phase_e phase;
        logic is_write;
        logic [4:0] wr_addr;
        logic [3:0] gpio;
        logic rdy_n;
        logic [4:0] hold;
        logic [15:0] conv;
        logic cmd_started;
        logic sdo;
        logic oe;
        logic so;
    } ahs_state_s;

    ahs_state_s state_reg;
    ahs_state_s state_next;

    logic cs_low;
    logic ck_rise;
    logic ck_fall;
    logic st_rise;
    logic [7:0] byte_in;
    logic byte_done;
    logic rdy_raise;
    logic port_clear;

    ////////////////////////////////////////////////////////////////////////
    // Rising edge of a synchronised level
    function automatic logic ahs_rise(
        input logic now_lvl,
        input logic was_lvl
    );
    begin
        return now_lvl && !was_lvl;
    end
    endfunction

    // Falling edge of a synchronised level
    function automatic logic ahs_fall(
        input logic now_lvl,
        input logic was_lvl
    );
    begin
        return !now_lvl && was_lvl;
    end
    endfunction

    // Next input byte with the new bit at the bottom
    function automatic logic [7:0] ahs_shift_in(
        input logic [7:0] sh,
        input logic bit_in
    );
    begin
        return {sh[6:0], bit_in};
    end
    endfunction

    // Opcode that writes a register
    function automatic logic ahs_is_write(
        input logic [7:0] op
    );
    begin
        return (op & `AHS_CMD_WRITE_MASK) == `AHS_CMD_WRITE;
    end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        state_next.cs_s = {state_reg.cs_s[0], select_n};
        state_next.ck_s = {state_reg.ck_s[0], sclk};
        state_next.di_s = {state_reg.di_s[0], sdi};
        state_next.st_s = {state_reg.st_s[0], start_pin};
        state_next.ck_d = state_reg.ck_s[1];
        state_next.st_d = state_reg.st_s[1];
        cs_low = !state_reg.cs_s[1];
        ck_rise = ahs_rise(state_reg.ck_s[1], state_reg.ck_d);
        ck_fall = ahs_fall(state_reg.ck_s[1], state_reg.ck_d);
        st_rise = ahs_rise(state_reg.st_s[1], state_reg.st_d);
        byte_in = ahs_shift_in(state_reg.shin, state_reg.di_s[1]);
        byte_done = state_reg.bitcnt == 3'h7;
        port_clear = !cs_low || (state_reg.bitcnt != 3'h0
            && state_reg.tmo == 16'(`AHS_TIMEOUT_CLKS - 1));
        rdy_raise = st_rise || (ck_rise && cs_low && !state_reg.cmd_started);

        // Byte timeout, counted in device clocks
        if (mod_clk_en && state_reg.bitcnt != 3'h0)
        begin
            state_next.tmo = state_reg.tmo + 16'h0001;
        end
        if (ck_rise && cs_low && state_reg.bitcnt == 3'h0)
        begin
            state_next.tmo = 16'h0000;
        end

        if (ck_rise && cs_low)
        begin
            state_next.sdo = state_reg.shout[15];
            state_next.shout = {state_reg.shout[14:0], 1'b0};
        end
        if (ck_fall && cs_low)
        begin
            state_next.shin = byte_in;
            state_next.bitcnt = state_reg.bitcnt + 3'h1;
            if (byte_done)
            begin
                // Next byte may start at once
                unique case (state_reg.phase)
                    AHS_CMD:
                    begin
                        state_next.is_write = ahs_is_write(byte_in);
                        state_next.wr_addr = byte_in[4:0];
                        state_next.phase = AHS_ARG;
                    end
                    AHS_ARG:
                    begin
                        state_next.phase = state_reg.is_write
                            ? AHS_DATA : AHS_CMD;
                    end
                    AHS_DATA:
                    begin
                        if (state_reg.wr_addr == `AHS_GPIO_REG_ADDR)
                        begin
                            state_next.gpio = byte_in[3:0];
                        end
                        state_next.phase = AHS_CMD;
                    end
                endcase
            end
        end

        // Select high or timeout clears the port
        if (port_clear)
        begin
            state_next.bitcnt = 3'h0;
            state_next.phase = AHS_CMD;
            state_next.tmo = 16'h0000;
        end
        state_next.oe = cs_low;

        // Ready pin: high on start or first clock, held at least 24 clocks
        state_next.cmd_started = cs_low && (state_reg.cmd_started
            || ck_rise);
        // Result word stays as loaded at the ready fall
        if (rdy_raise)
        begin
            state_next.rdy_n = 1'b1;
            state_next.hold = 5'h00;
            state_next.conv = 16'h0000;
        end
        else if (mod_clk_en && state_reg.rdy_n)
        begin
            if (state_reg.hold != 5'(`AHS_READY_HIGH_MIN))
            begin
                state_next.hold = state_reg.hold + 5'h01;
            end
            else if (state_reg.st_s[1])
            begin
                state_next.conv = state_reg.conv + 16'h0001;
                if (state_reg.conv == `AHS_CONV_CLKS)
                begin
                    state_next.rdy_n = 1'b0;
                    state_next.shout = result_word;
                end
            end
        end

        // Shared line shows ready while released
        state_next.so = state_next.oe ? state_next.sdo : state_next.rdy_n;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.phase <= AHS_CMD;
            state_reg.gpio <= `AHS_GPIO_RESET;
            state_reg.rdy_n <= 1'b1;
            state_reg.cs_s <= 2'b11;
            state_reg.so <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins straight from the state flops
    assign serial_out = state_reg.so;
    assign serial_out_oe = state_reg.oe;
    assign result_ready_n = state_reg.rdy_n;
    assign general_io_pin = state_reg.gpio;
endmodule

/* File: inc/ahs_consts.svh */
// Constants for the ADC host serial sequencing block
// How it works
// - Commands ignore ready timing; direct reads only
// - Ready goes high within two clocks
// - Ready stays high at least 24 clocks
// - Incomplete byte after 2^15 clocks resets port
// - Sample serial input on falling clock edges
// - Shift output bit after rising edge
// - Drive output only while select low
// - Update general outputs after write command ends
// - Bytes and commands may run back to back
`ifndef AHS_CONSTS_SVH
`define AHS_CONSTS_SVH
`define AHS_READY_HIGH_MIN 24
`define AHS_TIMEOUT_CLKS 32768
`define AHS_CMD_WRITE 8'h40
`define AHS_CMD_WRITE_MASK 8'hE0
`define AHS_GPIO_REG_ADDR 5'h11
`define AHS_GPIO_RESET 4'h0
`define AHS_CONV_CLKS 16'h0100
`endif

/* File: inc/ahs_pkg.sv */
// Types for the ADC host serial sequencing block
package ahs_pkg;
    typedef enum logic [1:0] {
        AHS_CMD,
        AHS_ARG,
        AHS_DATA
    } ahs_phase_e;
endpackage

/* File: sim/ahs_serial_chk.sv */
// Port checker for the host serial sequencing block
`timescale 1ns/1ps
module ahs_serial_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mod_clk_en,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic start_pin,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic result_ready_n,
    input wire logic [3:0] general_io_pin
);
    logic [7:0] hi_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Device clocks seen while ready is high
    always_ff @(posedge clk_sys or posedge rst)
        if (rst) hi_reg <= 8'h00;
        else if (!result_ready_n) hi_reg <= 8'h00;
        else if (mod_clk_en && hi_reg != 8'hff) hi_reg <= hi_reg + 8'h01;
    oe_drive_a: assert property ($fell(select_n) |-> ##[1:4] serial_out_oe)
        else $error("output not driven after select");
    oe_release_a: assert property ($rose(select_n) |-> ##[1:4] !serial_out_oe)
        else $error("output not released after select");
    oe_idle_a: assert property (select_n [*4] |=> !serial_out_oe)
        else $error("output driven while deselected");
    out_share_a: assert property (!serial_out_oe |-> serial_out == result_ready_n)
        else $error("shared line not showing ready");
    rdy_rise_a: assert property ($rose(start_pin) |-> ##[1:5] result_ready_n)
        else $error("ready not raised after start");
    rdy_hold_a: assert property ($fell(result_ready_n) |-> $past(hi_reg) >= 8'h18)
        else $error("ready high too briefly");
    gpio_sync_a: assert property (!$stable(general_io_pin) |-> !$past(select_n, 4))
        else $error("general outputs changed outside a write");
    dout_shift_a: assert property (serial_out_oe && $past(serial_out_oe, 2)
        && !$stable(serial_out) |-> $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5))
        else $error("output bit changed without rising clock");
    cover property (general_io_pin == 4'ha);
    cover property ($fell(result_ready_n));
    cover property ($rose(serial_out_oe));
endmodule
bind ahs_serial ahs_serial_chk u_ahs_serial_chk (.*);

/* File: sim/ahs_host_model.sv */
// Host serial controller model
`timescale 1ns/1ps
module ahs_host_model (
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic select_n = 1'b1,
    output logic sclk = 1'b0,
    output logic sdi = 1'b0,
    output logic start_pin = 1'b0
);
    // Bytes run back to back, MSB first
    task automatic xfer(input logic [23:0] w);
        @(negedge clk_sys) select_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            sdi = w[i];
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        select_n = 1'b1;
        sdi = ~sdi;
    endtask
    // Start level held ten system clocks
    task automatic start(input logic v);
        @(negedge clk_sys) start_pin = v;
        repeat (10) @(negedge clk_sys);
    endtask
    // Direct result read: clock idle low until ready falls
    task automatic read_direct(output logic [15:0] d, output int n);
        n = 0;
        d = 16'h0000;
        while (serial_out !== 1'b0 && n < 2000)
        begin
            @(negedge clk_sys);
            n++;
        end
        repeat (10) @(negedge clk_sys);
        select_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            d[i] = serial_out;
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        select_n = 1'b1;
    endtask
    // Cut byte: a few clocks, then silence with select low
    task automatic partial(input int n);
        @(negedge clk_sys) select_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            sdi = 1'b1;
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
        end
    endtask
endmodule

/* File: sim/ahs_serial_tb.sv */
// Self-checking testbench for the host serial sequencing block
`timescale 1ns/1ps
module ahs_serial_tb;
    import ahs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic mod_clk_en = 1'b0;
    logic select_n, sclk, sdi, start_pin, serial_out, serial_out_oe;
    logic result_ready_n;
    logic [15:0] result_word = 16'h5a3c;
    logic [3:0] general_io_pin;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    ahs_serial u_ahs_serial (.*);
    ahs_host_model u_ahs_host_model (.*);
    initial forever #10 clk_sys = ~clk_sys;
    always @(negedge clk_sys) mod_clk_en <= ~mod_clk_en;
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_write;
        u_ahs_host_model.xfer(24'h51_000a);
        repeat (4) @(negedge clk_sys);
        chk("gpio", 8'h0a, {4'h0, general_io_pin});
        chk("oe", 8'h00, {7'h0, serial_out_oe});
        u_ahs_host_model.xfer(24'h42_0005);
        repeat (4) @(negedge clk_sys);
        chk("gpio kept", 8'h0a, {4'h0, general_io_pin});
        $display("write test done");
    endtask
    task automatic t_start;
        int n;
        n = 0;
        u_ahs_host_model.start(1'b1);
        while (result_ready_n !== 1'b0 && n < 1000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk("ready late", 8'h01, {7'h0, n >= 520 && n <= 600});
        u_ahs_host_model.xfer(24'h42_0000);
        chk("ready cmd", 8'h01, {7'h0, result_ready_n});
        u_ahs_host_model.start(1'b0);
        $display("start test done");
    endtask
    task automatic t_read;
        logic [15:0] d;
        int n;
        u_ahs_host_model.start(1'b1);
        u_ahs_host_model.read_direct(d, n);
        chk("ready seen", 8'h01, {7'h0, n < 2000});
        chk("read hi", 8'h5a, d[15:8]);
        chk("read lo", 8'h3c, d[7:0]);
        u_ahs_host_model.start(1'b0);
        $display("direct read test done");
    endtask
    task automatic t_timeout;
        u_ahs_host_model.partial(4);
        repeat (65600) @(negedge clk_sys);
        u_ahs_host_model.xfer(24'h51_0005);
        repeat (4) @(negedge clk_sys);
        chk("gpio timeout", 8'h05, {4'h0, general_io_pin});
        $display("timeout test done");
    endtask
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("reset", 8'h10, {3'h0, result_ready_n, general_io_pin});
        repeat (8200) @(negedge clk_sys);
        t_write();
        t_start();
        t_read();
        t_timeout();
        wrap_up();
    end
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 85000)
        begin
            fail_count++;
            wrap_up();
        end
    end
endmodule
